// >>> hdl/capture_pwm_channel.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "capture_pwm_regs.svh"
module capture_pwm_channel
  import capture_pwm_pkg::*;
#(
  parameter bit PIN_ALT_SELECT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire time_bases_t time_bases_i,
  input wire logic port_c_pin_one_i,
  input wire logic port_e_pin_seven_i,
  output logic pwm_o,
  output logic irq_o
);
  logic [7:0] capture_low_byte, next_capture_low_byte;
  logic [7:0] capture_high_byte, next_capture_high_byte;
  chan_ctl_t channel_control, next_channel_control;
  logic [7:0] period_timer_count, next_period_timer_count;
  logic [7:0] period_timer_limit, next_period_timer_limit;
  logic [6:0] period_timer_control, next_period_timer_control;
  logic [7:0] irq_status, next_irq_status;
  logic [7:0] irq_mask, next_irq_mask;
  logic timebase_sel, next_timebase_sel;
  logic [3:0] pre_div, next_pre_div;
  logic [9:0] duty_latch, next_duty_latch;
  logic [1:0] fine, next_fine;
  logic next_pwm;
  logic [31:0] next_rdata;
  logic next_ack;
  logic wr, rd_hit, capture_mode, pwm_mode, fire, tick, channel_pin;
  logic [15:0] base;
  logic [7:0] wbyte;
  event_sel_t ev_sel;

  // fixed by strap, not run-time logic
  assign channel_pin = PIN_ALT_SELECT ? port_e_pin_seven_i : port_c_pin_one_i;
  assign base = timebase_sel ? time_bases_i.second_time_base
                             : time_bases_i.first_time_base;
  assign capture_mode = channel_control.mode[3:2] == `MODE_CAP_FALL >> 2;
  assign pwm_mode = channel_control.mode[3:2] == `MODE_PWM_LO >> 2;
  assign ev_sel = event_sel_t'(channel_control.mode[1:0]);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  assign wbyte = wb_dat_i[7:0];
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  edge_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(channel_pin),
    .active_i(capture_mode),
    .sel_i(ev_sel),
    .fire_o(fire)
  );

  // period timer prescale 1/4/16 as an enable pulse
  always_comb begin
    next_pre_div = pre_div + 4'h1;
    tick = 1'b0;
    case (period_timer_control[1:0])
      2'h0: tick = 1'b1;
      2'h1: tick = pre_div[1:0] == `PRESCALE_FOUR;
      default: tick = pre_div == `PRESCALE_SIXTEEN;
    endcase
    if (!period_timer_control[`T2_ON_BIT]) next_pre_div = 4'h0;
  end

  always_comb begin
    next_capture_low_byte = capture_low_byte;
    next_capture_high_byte = capture_high_byte;
    next_channel_control = channel_control;
    next_period_timer_count = period_timer_count;
    next_period_timer_limit = period_timer_limit;
    next_period_timer_control = period_timer_control;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_timebase_sel = timebase_sel;
    next_duty_latch = duty_latch;
    next_fine = fine;
    next_pwm = pwm_o;
    if (wr) begin
      case (wb_adr_i)
        `OFS_CAPTURE_LOW: next_capture_low_byte = wbyte;
        `OFS_CAPTURE_HIGH: next_capture_high_byte = wbyte;
        `OFS_CHANNEL_CONTROL: next_channel_control = chan_ctl_t'(wbyte[5:0]);
        `OFS_PERIOD_COUNT: next_period_timer_count = wbyte;
        `OFS_PERIOD_LIMIT: next_period_timer_limit = wbyte;
        `OFS_PERIOD_CONTROL: next_period_timer_control = wbyte[6:0];
        `OFS_IRQ_STATUS: next_irq_status = irq_status & ~wbyte;
        `OFS_IRQ_MASK: next_irq_mask = wbyte;
        `OFS_TIMEBASE_SEL: next_timebase_sel = wbyte[0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // capture after the write so hardware wins both the data and the flag
    if (fire && capture_mode) begin
      next_capture_low_byte = base[7:0];
      next_capture_high_byte = base[15:8];
      next_irq_status[`IRQ_CAPTURE_BIT] = 1'b1;
    end
    // pwm: 10-bit count of timer value and fine phase vs latched duty
    if (pwm_mode && period_timer_control[`T2_ON_BIT]) begin
      // fine phase steps on the prescaled tick so any prescale keeps alignment
      if (tick) next_fine = fine + 2'h1;
      if (tick && fine == 2'h3) begin
        if (period_timer_count == period_timer_limit) begin
          next_period_timer_count = `RST_ZERO8;
          next_duty_latch = {capture_low_byte, channel_control.duty_low};
          next_pwm = 1'b1;
        end else begin
          next_period_timer_count = period_timer_count + 8'h1;
        end
      end
      // compare next values so the high time is exactly duty fine steps
      if ({next_period_timer_count, next_fine} == next_duty_latch) next_pwm = 1'b0;
    end else begin
      next_pwm = 1'b0;
      next_fine = 2'h0;
      if (period_timer_control[`T2_ON_BIT] && tick) begin
        next_period_timer_count = period_timer_count == period_timer_limit ?
          `RST_ZERO8 : period_timer_count + 8'h1;
      end
    end
  end

  always_comb begin
    next_ack = rd_hit;
    next_rdata = 32'h0;
    case (wb_adr_i)
      `OFS_CAPTURE_LOW: next_rdata[7:0] = capture_low_byte;
      `OFS_CAPTURE_HIGH: next_rdata[7:0] = capture_high_byte;
      `OFS_CHANNEL_CONTROL: next_rdata[5:0] = channel_control;
      `OFS_PERIOD_COUNT: next_rdata[7:0] = period_timer_count;
      `OFS_PERIOD_LIMIT: next_rdata[7:0] = period_timer_limit;
      `OFS_PERIOD_CONTROL: next_rdata[6:0] = period_timer_control;
      `OFS_IRQ_STATUS: next_rdata[7:0] = irq_status;
      `OFS_IRQ_MASK: next_rdata[7:0] = irq_mask;
      `OFS_TIMEBASE_SEL: next_rdata[0] = timebase_sel;
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_low_byte <= `RST_ZERO8;
      capture_high_byte <= `RST_ZERO8;
      channel_control <= chan_ctl_t'(6'h00);
      period_timer_count <= `RST_ZERO8;
      period_timer_limit <= `RST_PERIOD_LIMIT;
      period_timer_control <= 7'h00;
      irq_status <= `RST_ZERO8;
      irq_mask <= `RST_ZERO8;
      timebase_sel <= 1'b0;
      pre_div <= 4'h0;
      duty_latch <= 10'h000;
      fine <= 2'h0;
      pwm_o <= 1'b0;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      capture_low_byte <= next_capture_low_byte;
      capture_high_byte <= next_capture_high_byte;
      channel_control <= next_channel_control;
      period_timer_count <= next_period_timer_count;
      period_timer_limit <= next_period_timer_limit;
      period_timer_control <= next_period_timer_control;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      timebase_sel <= next_timebase_sel;
      pre_div <= next_pre_div;
      duty_latch <= next_duty_latch;
      fine <= next_fine;
      pwm_o <= next_pwm;
      wb_dat_o <= next_rdata;
      wb_ack_o <= next_ack;
      irq_o <= |(next_irq_status & next_irq_mask);
    end
  end

  capture_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && capture_mode |=> {capture_high_byte, capture_low_byte} == $past(base))
    else $error("capture value wrong");
  flag_same_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && capture_mode |=> irq_status[`IRQ_CAPTURE_BIT])
    else $error("flag not set with capture");
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_status[`IRQ_CAPTURE_BIT] && !(wr && wb_adr_i == `OFS_IRQ_STATUS)
    |=> irq_status[`IRQ_CAPTURE_BIT]) else $error("flag dropped by hardware");
  no_capture_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !capture_mode && !wr |=> $stable({capture_high_byte, capture_low_byte}))
    else $error("capture outside capture mode");
  irq_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_mask[`IRQ_CAPTURE_BIT] && irq_mask[7:3] == 5'h0 && irq_mask[1:0] == 2'h0
    |=> !irq_o || $past(wr)) else $error("masked irq raised");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  pwm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_mode |=> !pwm_o) else $error("pwm active outside pwm mode");
endmodule : capture_pwm_channel

// >>> hdl/capture_pwm_regs.svh
`ifndef CAPTURE_PWM_REGS_SVH
`define CAPTURE_PWM_REGS_SVH
`define OFS_CAPTURE_LOW 8'h00
`define OFS_CAPTURE_HIGH 8'h04
`define OFS_CHANNEL_CONTROL 8'h08
`define OFS_PERIOD_COUNT 8'h0c
`define OFS_PERIOD_LIMIT 8'h10
`define OFS_PERIOD_CONTROL 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_TIMEBASE_SEL 8'h20
`define RST_PERIOD_LIMIT 8'hff
`define RST_ZERO8 8'h00
`define CTL_MODE_LSB 0
`define CTL_DUTY_LSB 4
`define IRQ_CAPTURE_BIT 2
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_PWM_LO 4'hc
`define PRESCALE_FOUR 4'h3
`define PRESCALE_SIXTEEN 4'hf
`define T2_ON_BIT 2
`define T2_PS_LSB 0
`endif

// >>> hdl/capture_pwm_pkg.sv
package capture_pwm_pkg;
  typedef enum logic [1:0] {ev_fall, ev_rise, ev_rise4, ev_rise16} event_sel_t;
  typedef struct packed {
    logic [1:0] duty_low;
    logic [3:0] mode;
  } chan_ctl_t;
  typedef struct packed {
    logic [15:0] first_time_base;
    logic [15:0] second_time_base;
  } time_bases_t;
endpackage : capture_pwm_pkg

// >>> hdl/edge_prescaler.sv
`timescale 1ns/1ps
`include "capture_pwm_regs.svh"
module edge_prescaler
  import capture_pwm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic active_i,
  input wire event_sel_t sel_i,
  output logic fire_o
);
  logic sync1, sync2, last;
  logic [3:0] count, next_count;
  logic next_fire;
  logic rise, fall;
  assign rise = sync2 & ~last;
  assign fall = ~sync2 & last;
  always_comb begin
    next_count = count;
    next_fire = 1'b0;
    if (!active_i) begin
      next_count = 4'h0;
    end else begin
      case (sel_i)
        ev_fall: next_fire = fall;
        ev_rise: next_fire = rise;
        ev_rise4: begin
          // counter kept across prescale switches, first fire may be early
          if (rise) next_count = count + 4'h1;
          next_fire = rise && count[1:0] == `PRESCALE_FOUR;
        end
        ev_rise16: begin
          if (rise) next_count = count + 4'h1;
          next_fire = rise && count == `PRESCALE_SIXTEEN;
        end
        default: next_fire = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      count <= 4'h0;
      fire_o <= 1'b0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      last <= sync2;
      count <= next_count;
      fire_o <= next_fire;
    end
  end
  prescale_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !active_i |=> count == 4'h0) else $error("prescaler not cleared");
endmodule : edge_prescaler

// >>> testbench/edge_source.sv
`timescale 1ns/1ps
module edge_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [4:0] count_i,
  input wire logic [15:0] now_i,
  output logic pin_o,
  output logic busy_o,
  output logic [15:0] stamp_o
);
  logic [5:0] left = 6'h00;
  logic [2:0] ph = 3'h0;
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    stamp_o = 16'h0000;
  end
  // count_i rising edges, each level held 8 clocks
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      left <= {count_i, 1'b0};
      busy_o <= 1'b1;
    end else if (busy_o) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        pin_o <= ~pin_o;
        stamp_o <= now_i;
        left <= left - 6'h01;
        busy_o <= (left != 6'h01);
      end
    end
  end
endmodule : edge_source

// >>> testbench/tb_capture_pwm_channel.sv
`timescale 1ns/1ps
`include "capture_pwm_regs.svh"
module tb_capture_pwm_channel
  import capture_pwm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic [15:0] tcnt = 16'h0000;
  logic [15:0] stamp;
  logic [4:0] cnt = 5'h00;
  logic pin, busy, ack, pwm, irq;
  int fail_count = 0;
  int total_checks = 0;
  time_bases_t bases;
  assign bases = '{first_time_base: tcnt, second_time_base: ~tcnt};
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) tcnt <= tcnt + 16'h0001;
  // unselected pin carries the inverse so a wrong pick shows up
  capture_pwm_channel i_capture_pwm_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack), .time_bases_i(bases), .port_c_pin_one_i(pin),
    .port_e_pin_seven_i(~pin), .pwm_o(pwm), .irq_o(irq));
  edge_source i_edge_source (.clk_i(clk_i), .go_i(go), .count_i(cnt), .now_i(tcnt),
    .pin_o(pin), .busy_o(busy), .stamp_o(stamp));
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("[ERR] ack expected 1 seen %b", ack);
    end
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_win(input string nm, input logic [15:0] b, input logic [15:0] g);
    logic [15:0] d;
    d = g - b;
    total_checks++;
    if ((d < 16'h0008) !== 1'b1) begin
      fail_count++;
      $display("[ERR] %s expected %h+0..7 seen %h", nm, b, g);
    end
  endtask : chk_win
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, e, rdat[7:0]);
  endtask : rdchk
  task automatic pulses(input logic [4:0] n);
    int k;
    @(posedge clk_i);
    cnt <= n;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k < 600 && busy; k++) @(posedge clk_i);
    if (busy !== 1'b0) begin
      fail_count++;
      $display("[ERR] busy expected 0 seen %b", busy);
    end
    repeat (10) @(posedge clk_i);
  endtask : pulses
  task automatic pair(output logic [15:0] v);
    wb(1'b0, `OFS_CAPTURE_LOW, 8'h00);
    v[7:0] = rdat[7:0];
    wb(1'b0, `OFS_CAPTURE_HIGH, 8'h00);
    v[15:8] = rdat[7:0];
  endtask : pair
  task automatic t_reset();
    rdchk("limit", `OFS_PERIOD_LIMIT, 8'hff);
    rdchk("control", `OFS_CHANNEL_CONTROL, 8'h00);
    rdchk("status", `OFS_IRQ_STATUS, 8'h00);
    wb(1'b1, 8'h24, 8'h5a);
    rdchk("unmapped", 8'h24, 8'h00);
    wb(1'b1, `OFS_IRQ_MASK, 8'h04);
  endtask : t_reset
  task automatic prescale(input logic [3:0] m, input logic [4:0] n, input logic [15:0] off);
    logic [15:0] v;
    wb(1'b1, `OFS_CHANNEL_CONTROL, 8'h00);
    wb(1'b1, `OFS_CHANNEL_CONTROL, {4'h0, m});
    wb(1'b1, `OFS_IRQ_STATUS, 8'h04);
    if (n > 5'h01) pulses(n - 5'h01);
    rdchk("status_early", `OFS_IRQ_STATUS, 8'h00);
    pulses(5'h01);
    rdchk("status", `OFS_IRQ_STATUS, 8'h04);
    chk("irq", 8'h01, {7'h0, irq});
    pair(v);
    chk_win("pair", stamp - off, v);
  endtask : prescale
  task automatic t_modes();
    prescale(`MODE_CAP_FALL, 5'd1, 16'h0000);
    prescale(`MODE_CAP_RISE, 5'd1, 16'h0008);
    prescale(`MODE_CAP_RISE4, 5'd4, 16'h0008);
    prescale(`MODE_CAP_RISE16, 5'd16, 16'h0008);
    // partial count left behind must vanish on the off write
    pulses(5'd2);
    prescale(`MODE_CAP_RISE4, 5'd4, 16'h0008);
  endtask : t_modes
  task automatic t_overwrite();
    logic [15:0] v;
    prescale(`MODE_CAP_RISE, 5'd1, 16'h0008);
    pulses(5'd1);
    pair(v);
    chk_win("overwrite", stamp - 16'h0008, v);
    wb(1'b1, `OFS_IRQ_STATUS, 8'h04);
    rdchk("cleared", `OFS_IRQ_STATUS, 8'h00);
    chk("irq_clear", 8'h00, {7'h0, irq});
  endtask : t_overwrite
  task automatic t_select();
    logic [15:0] v;
    wb(1'b1, `OFS_TIMEBASE_SEL, 8'h01);
    pulses(5'd1);
    pair(v);
    chk_win("second_base", stamp - 16'h0008, ~v);
    chk("irq_set", 8'h01, {7'h0, irq});
    wb(1'b1, `OFS_IRQ_MASK, 8'h00);
    chk("irq_masked", 8'h00, {7'h0, irq});
  endtask : t_select
  task automatic t_pwm();
    logic [7:0] hi;
    int k;
    hi = 8'h00;
    go <= 1'b0;
    wb(1'b1, `OFS_PERIOD_LIMIT, 8'h03);
    wb(1'b1, `OFS_CAPTURE_LOW, 8'h02);
    wb(1'b1, `OFS_PERIOD_CONTROL, 8'h04);
    wb(1'b1, `OFS_CHANNEL_CONTROL, 8'h1c);
    repeat (40) @(posedge clk_i);
    // four whole periods of 16 clocks, duty 9 fine steps each
    for (k = 0; k < 64; k++) begin
      @(posedge clk_i);
      if (pwm === 1'b1) hi = hi + 8'h01;
    end
    chk("pwm_high", 8'h24, hi);
    wb(1'b1, `OFS_CHANNEL_CONTROL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("pwm_off", 8'h00, {7'h0, pwm});
  endtask : t_pwm
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_overwrite();
    t_select();
    t_pwm();
    print_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_capture_pwm_channel
